// File: rtl/lmf_frame_ctrl.sv
// frame control of a chained led matrix driver, axi4-lite register slave
// assumes one clock, synchronous detection flag inputs from the analog side
// Operation
// - first two config registers hold writes pending until next frame sync
// - cfg2 register takes effect at once on write, blank register only at next frame sync
// - frame sync shows last frame while current frame is being received
// - chip index command gives this device its own chain address
// - register reads are answered at any point within a frame
// - config writes are accepted in broadcast mode by every device
// - grayscale data is written to memory only when addressed to this device
// - line switch time in grayscale clocks, code 0011b gives 120
// - ten-bit field sets grayscale clocks per scan segment
// - six-bit field adds that many blank clocks per sub-period
// - frame blank above sub-periods times lines is spread over segments
// - leftover blank above sub-period count is spread over sub-periods
// - grayscale clock rate derives from a multiplier field
// - eight read registers return open and short detection flags
// - short flag registers hold one read-only bit per channel, 1 is fault
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module lmf_frame_ctrl #(
   parameter int MEM_WORDS = 128
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [47:0] open_flag_i,
   input wire logic [47:0] short_flag_i,
   output logic [7:0] chip_index_o,
   output logic [47:0] cfg_first_o,
   output logic [5:0] line_sel_o,
   output logic seg_active_o,
   output logic [15:0] gs_data_o,
   output logic irq_o
);
   import lmf_pkg::*;

   localparam int AW = $clog2(MEM_WORDS);

   if (MEM_WORDS < 64 || MEM_WORDS != (1 << AW)) begin : g_chk
      $error("MEM_WORDS must be a power of two of at least 64");
   end

   function automatic logic [31:0] flag_word(input logic [2:0] k, input logic [47:0] op,
                                             input logic [47:0] sh);
      logic [47:0] src;
      src = k[2] ? sh : op;
      flag_word = {20'h0, src[k[1:0]*FLAG_SLICE +: FLAG_SLICE]};
   endfunction

   logic aw_full, next_aw_full, w_full, next_w_full;
   logic [7:0] awaddr, next_awaddr, tgt_addr, next_tgt_addr, chip_idx, next_chip_idx;
   logic [31:0] wdata, next_wdata;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic awready, next_awready, wready, next_wready, arready, next_arready;
   logic [47:0] cfg0_pend, next_cfg0_pend, cfg1_pend, next_cfg1_pend;
   lmf_geom_t geom, next_geom;
   logic [23:0] blank_total, next_blank_total;
   logic idx_valid, next_idx_valid, bcast, next_bcast;
   logic [AW-1:0] gs_addr, next_gs_addr;
   logic vsync_pulse, next_vsync_pulse;
   logic [ST_W-1:0] stat, next_stat, mask, next_mask;
   logic irq, next_irq;
   logic [7:0] chip_out, next_chip_out;
   logic [47:0] open_q, short_q, next_open_q, next_short_q;
   logic gs_we;
   logic wr_go, hit_me;

   lmf_state_t st, next_st;
   logic [16:0] cnt, next_cnt, seg_total, next_seg_total, sw_total, next_sw_total;
   logic [16:0] blk_total, next_blk_total, step;
   logic [5:0] line, next_line, subp, next_subp;
   logic disp_bank, next_disp_bank, seg_act, next_seg_act;
   logic [47:0] cfg0, next_cfg0;
   logic ev_start, ev_end;
   logic [15:0] gs_rd, next_gs_rd;
   logic [15:0] mem [0:2*MEM_WORDS-1];
   logic [12:0] slots;
   logic [23:0] per_seg, rem, per_sub;

   always_comb begin
      next_aw_full = aw_full;
      next_awaddr = awaddr;
      next_w_full = w_full;
      next_wdata = wdata;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_cfg0_pend = cfg0_pend;
      next_cfg1_pend = cfg1_pend;
      next_geom = geom;
      next_blank_total = blank_total;
      next_tgt_addr = tgt_addr;
      next_bcast = bcast;
      next_chip_idx = chip_idx;
      next_idx_valid = idx_valid;
      next_chip_out = chip_out;
      next_gs_addr = gs_addr;
      next_mask = mask;
      next_vsync_pulse = 1'b0;
      next_open_q = open_flag_i;
      next_short_q = short_flag_i;
      gs_we = 1'b0;
      hit_me = idx_valid && tgt_addr == chip_idx;
      if (s_axi_awvalid_i && awready) begin
         next_aw_full = 1'b1;
         next_awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready) begin
         next_w_full = 1'b1;
         next_wdata = s_axi_wdata_i;
      end
      if (bvalid && s_axi_bready_i) begin
         next_bvalid = 1'b0;
      end
      wr_go = aw_full && w_full && !bvalid;
      next_stat = stat;
      if (wr_go) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         unique case (awaddr)
            A_CMD: next_vsync_pulse = wdata[CMD_VSYNC_BIT];
            A_CHIP_IDX: begin
               next_chip_idx = wdata[7:0];
               next_idx_valid = 1'b1;
               next_chip_out = wdata[7:0] + 8'h01;
            end
            A_TARGET: begin
               next_tgt_addr = wdata[7:0];
               next_bcast = wdata[TGT_BCAST_BIT];
            end
            A_CFG0_LO: if (bcast || hit_me) next_cfg0_pend[31:0] = wdata;
            A_CFG0_HI: if (bcast || hit_me) next_cfg0_pend[47:32] = wdata[15:0];
            A_CFG1_LO: if (bcast || hit_me) next_cfg1_pend[31:0] = wdata;
            A_CFG1_HI: if (bcast || hit_me) next_cfg1_pend[47:32] = wdata[15:0];
            A_CFG2: if (bcast || hit_me) next_geom = wdata;
            A_BLANK: if (bcast || hit_me) next_blank_total = wdata[23:0];
            A_GS_ADDR: next_gs_addr = wdata[AW-1:0];
            A_GS_DATA: begin
               gs_we = !bcast && hit_me;
               next_gs_addr = gs_addr + AW'(1);
            end
            A_STAT: next_stat = stat & ~wdata[ST_W-1:0];
            A_MASK: next_mask = wdata[ST_W-1:0];
            default: begin
               if (awaddr < A_FLAG_BASE || awaddr > A_FLAG_LAST || awaddr[1:0] != 2'h0) begin
                  next_bresp = RESP_SLVERR;
               end
            end
         endcase
      end
      // hardware set wins over a same-cycle clear
      next_stat[ST_FRAME_START] = next_stat[ST_FRAME_START] | ev_start;
      next_stat[ST_FRAME_END] = next_stat[ST_FRAME_END] | ev_end;
      next_stat[ST_FAULT] = next_stat[ST_FAULT] |
                            (|(open_flag_i & ~open_q)) | (|(short_flag_i & ~short_q));
      next_irq = |(next_stat & mask);
      next_awready = !next_aw_full;
      next_wready = !next_w_full;
      if (rvalid && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && arready) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0;
         unique case (s_axi_araddr_i)
            A_CMD: next_rdata = 32'h0;
            A_CHIP_IDX: next_rdata = {23'h0, idx_valid, chip_idx};
            A_TARGET: next_rdata = {23'h0, bcast, tgt_addr};
            A_CFG0_LO: next_rdata = cfg0_pend[31:0];
            A_CFG0_HI: next_rdata = {16'h0, cfg0_pend[47:32]};
            A_CFG1_LO: next_rdata = cfg1_pend[31:0];
            A_CFG1_HI: next_rdata = {16'h0, cfg1_pend[47:32]};
            A_CFG2: next_rdata = geom;
            A_BLANK: next_rdata = {8'h0, blank_total};
            A_GS_ADDR: next_rdata = 32'(gs_addr);
            A_GS_DATA: next_rdata = 32'h0;
            A_STAT: next_rdata = 32'(stat);
            A_MASK: next_rdata = 32'(mask);
            A_FRAME: next_rdata = {17'h0, disp_bank, 2'(st), subp, line};
            default: begin
               if (s_axi_araddr_i >= A_FLAG_BASE && s_axi_araddr_i <= A_FLAG_LAST &&
                   s_axi_araddr_i[1:0] == 2'h0) begin
                  next_rdata = flag_word(s_axi_araddr_i[4:2], open_q, short_q);
               end else begin
                  next_rresp = RESP_SLVERR;
               end
            end
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         aw_full <= 1'b0;
         awaddr <= 8'h0;
         w_full <= 1'b0;
         wdata <= 32'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         cfg0_pend <= CFG_RST;
         cfg1_pend <= CFG_RST;
         geom <= GEOM_RST;
         blank_total <= 24'h0;
         tgt_addr <= 8'h0;
         bcast <= 1'b0;
         chip_idx <= 8'h0;
         idx_valid <= 1'b0;
         chip_out <= 8'h0;
         gs_addr <= '0;
         vsync_pulse <= 1'b0;
         stat <= '0;
         mask <= '0;
         irq <= 1'b0;
         open_q <= 48'h0;
         short_q <= 48'h0;
      end else begin
         aw_full <= next_aw_full;
         awaddr <= next_awaddr;
         w_full <= next_w_full;
         wdata <= next_wdata;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
         cfg0_pend <= next_cfg0_pend;
         cfg1_pend <= next_cfg1_pend;
         geom <= next_geom;
         blank_total <= next_blank_total;
         tgt_addr <= next_tgt_addr;
         bcast <= next_bcast;
         chip_idx <= next_chip_idx;
         idx_valid <= next_idx_valid;
         chip_out <= next_chip_out;
         gs_addr <= next_gs_addr;
         vsync_pulse <= next_vsync_pulse;
         stat <= next_stat;
         mask <= next_mask;
         irq <= next_irq;
         open_q <= next_open_q;
         short_q <= next_short_q;
      end
   end

   // receive bank is the one not on display
   always_ff @(posedge clk_i) begin
      if (gs_we) begin
         mem[{~disp_bank, gs_addr}] <= wdata[15:0];
      end
   end

   always_comb begin
      step = 17'(geom.grayscale_clock_multiplier_sel) + 17'h1;
      slots = 13'(({7'h0, geom.subperiods_m1} + 13'h1) * ({7'h0, geom.scan_lines_m1} + 13'h1));
      per_seg = (blank_total > 24'(slots)) ? blank_total / 24'(slots) : 24'h0;
      rem = blank_total - 24'(per_seg * 24'(slots));
      per_sub = (rem > 24'(geom.subperiods_m1) + 24'h1) ?
                rem / (24'(geom.subperiods_m1) + 24'h1) : 24'h0;
      next_st = st;
      next_cnt = (cnt > step) ? cnt - step : 17'h0;
      next_line = line;
      next_subp = subp;
      next_disp_bank = disp_bank;
      next_seg_total = seg_total;
      next_sw_total = sw_total;
      next_blk_total = blk_total;
      next_cfg0 = cfg0;
      ev_start = 1'b0;
      ev_end = 1'b0;
      if (vsync_pulse) begin
         next_cfg0 = cfg0_pend;
         next_disp_bank = ~disp_bank;
         next_seg_total = 17'(cfg1_pend[9:0]) + 17'(per_seg);
         next_sw_total = (17'(cfg1_pend[40:37]) + 17'h1) * LINE_SW_UNIT;
         next_blk_total = 17'(cfg1_pend[46:41]) + 17'(per_sub);
         next_cnt = 17'(cfg1_pend[9:0]) + 17'(per_seg);
         next_line = 6'h0;
         next_subp = 6'h0;
         next_st = ST_SEG;
         ev_start = 1'b1;
      end else if (cnt <= step) begin
         unique case (st)
            ST_IDLE: next_cnt = 17'h0;
            ST_SEG: begin
               next_st = ST_SWITCH;
               next_cnt = sw_total;
            end
            ST_SWITCH: begin
               if (line == geom.scan_lines_m1) begin
                  next_line = 6'h0;
                  next_st = ST_BLANK;
                  next_cnt = blk_total;
               end else begin
                  next_line = line + 6'h1;
                  next_st = ST_SEG;
                  next_cnt = seg_total;
               end
            end
            ST_BLANK: begin
               if (subp == geom.subperiods_m1) begin
                  next_st = ST_IDLE;
                  ev_end = 1'b1;
               end else begin
                  next_subp = subp + 6'h1;
                  next_st = ST_SEG;
                  next_cnt = seg_total;
               end
            end
         endcase
      end
      next_seg_act = (next_st == ST_SEG);
      next_gs_rd = mem[{next_disp_bank, AW'(next_line)}];
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st <= ST_IDLE;
         cnt <= 17'h0;
         line <= 6'h0;
         subp <= 6'h0;
         disp_bank <= 1'b0;
         seg_total <= 17'h0;
         sw_total <= 17'h0;
         blk_total <= 17'h0;
         cfg0 <= CFG_RST;
         seg_act <= 1'b0;
         gs_rd <= 16'h0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         line <= next_line;
         subp <= next_subp;
         disp_bank <= next_disp_bank;
         seg_total <= next_seg_total;
         sw_total <= next_sw_total;
         blk_total <= next_blk_total;
         cfg0 <= next_cfg0;
         seg_act <= next_seg_act;
         gs_rd <= next_gs_rd;
      end
   end

   assign s_axi_awready_o = awready;
   assign s_axi_wready_o = wready;
   assign s_axi_bvalid_o = bvalid;
   assign s_axi_bresp_o = bresp;
   assign s_axi_arready_o = arready;
   assign s_axi_rvalid_o = rvalid;
   assign s_axi_rdata_o = rdata;
   assign s_axi_rresp_o = rresp;
   assign chip_index_o = chip_out;
   assign cfg_first_o = cfg0;
   assign line_sel_o = line;
   assign seg_active_o = seg_act;
   assign gs_data_o = gs_rd;
   assign irq_o = irq;
endmodule

// File: rtl/lmf_pkg.sv
// constants, register map and field layouts of the led matrix frame control
// assumes a 32-bit axi4-lite master and a 100 mhz system clock
package lmf_pkg;
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_CHIP_IDX = 8'h04;
   localparam logic [7:0] A_CFG0_LO = 8'h08;
   localparam logic [7:0] A_CFG0_HI = 8'h0c;
   localparam logic [7:0] A_CFG1_LO = 8'h10;
   localparam logic [7:0] A_CFG1_HI = 8'h14;
   localparam logic [7:0] A_CFG2 = 8'h18;
   localparam logic [7:0] A_TARGET = 8'h1c;
   localparam logic [7:0] A_GS_ADDR = 8'h20;
   localparam logic [7:0] A_GS_DATA = 8'h24;
   localparam logic [7:0] A_BLANK = 8'h28;
   localparam logic [7:0] A_STAT = 8'h2c;
   localparam logic [7:0] A_MASK = 8'h30;
   localparam logic [7:0] A_FRAME = 8'h34;
   localparam logic [7:0] A_FLAG_BASE = 8'h40;
   localparam logic [7:0] A_FLAG_LAST = 8'h5c;
   localparam int FLAG_SLICE = 12;
   localparam int TGT_BCAST_BIT = 8;
   localparam int CMD_VSYNC_BIT = 0;
   localparam int ST_FRAME_START = 0;
   localparam int ST_FRAME_END = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_W = 3;
   localparam logic [16:0] LINE_SW_UNIT = 17'h0001e;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [47:0] CFG_RST = 48'h0;
   localparam logic [31:0] GEOM_RST = 32'h0;

   typedef struct packed {
      logic rsv_hi;
      logic [5:0] blank_subperiod_adjust;
      logic [3:0] line_switch_cycles;
      logic [26:0] rsv;
      logic [9:0] seg_len;
   } lmf_cfg2_t;

   typedef struct packed {
      logic [15:0] rsv;
      logic [5:0] subperiods_m1;
      logic [5:0] scan_lines_m1;
      logic [3:0] grayscale_clock_multiplier_sel;
   } lmf_geom_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEG = 2'b01,
      ST_SWITCH = 2'b10,
      ST_BLANK = 2'b11
   } lmf_state_t;
endpackage

// File: tb/lmf_frame_ctrl_checker.sv
// assertions on the register slave ports of the frame control
// bound to lmf_frame_ctrl from the testbench top, sees top ports only
`timescale 1ns/1ps
module lmf_frame_ctrl_checker (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [47:0] short_flag_i,
   input wire logic [47:0] cfg_first_o,
   input wire logic irq_o
);
   import lmf_pkg::*;
   logic [3:0] sync_age, next_sync_age;
   logic aw_go, ar_go;
   function automatic logic bad(input logic [7:0] a);
      return (a[1:0] != 2'h0) || (a > A_FRAME && a < A_FLAG_BASE) || (a > A_FLAG_LAST);
   endfunction
   assign aw_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   assign ar_go = s_axi_arvalid_i && s_axi_arready_o;
   // cycles since a sync write
   always_comb begin
      next_sync_age = sync_age;
      if (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == A_CMD) begin
         next_sync_age = 4'h0;
      end else if (sync_age != 4'hf) begin
         next_sync_age = sync_age + 4'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync_age <= 4'hf;
      end else begin
         sync_age <= next_sync_age;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_wr_lat;
      aw_go |-> !s_axi_bvalid_o ##2 s_axi_bvalid_o;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_rd_lat;
      ar_go |=> s_axi_rvalid_o;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_cfg_sync;
      !$stable(cfg_first_o) |-> sync_age < 4'hc;
   endproperty
   a_cfg_sync: assert property (p_cfg_sync) else $error("first config moved");
   property p_b_hold;
      s_axi_bvalid_o |=> $stable(s_axi_bresp_o);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response moved");
   property p_rd_bad;
      ar_go && bad(s_axi_araddr_i) |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0;
   endproperty
   a_rd_bad: assert property (p_rd_bad) else $error("unmapped read accepted");
   property p_wr_bad;
      aw_go && bad(s_axi_awaddr_i) |-> ##2 s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR;
   endproperty
   a_wr_bad: assert property (p_wr_bad) else $error("unmapped write accepted");
   property p_short_rd;
      ar_go && s_axi_araddr_i == 8'h50 |=> s_axi_rdata_o[11:0] == $past(short_flag_i[11:0], 2);
   endproperty
   a_short_rd: assert property (p_short_rd) else $error("short flags wrong");
   c_wr: cover property (aw_go ##2 s_axi_bvalid_o);
   c_rd_bad: cover property (ar_go && bad(s_axi_araddr_i));
   c_irq: cover property ($rose(irq_o));
endmodule

// File: tb/lmf_det_model.sv
// led open and short detector model driving the per-channel flags
// assumes new flag values arrive synchronous to the system clock
`timescale 1ns/1ps
module lmf_det_model (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input wire logic [47:0] open_val_i,
   input wire logic [47:0] short_val_i,
   output logic [47:0] open_flag_o,
   output logic [47:0] short_flag_o
);
   logic [47:0] next_open;
   logic [47:0] next_short;
   always_comb begin
      next_open = open_flag_o;
      next_short = short_flag_o;
      if (load_i) begin
         // one bit per channel, a one marks a faulty channel
         next_open = open_val_i;
         next_short = short_val_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         open_flag_o <= 48'h0;
         short_flag_o <= 48'h0;
      end else begin
         open_flag_o <= next_open;
         short_flag_o <= next_short;
      end
   end
endmodule

// File: tb/testbench.sv
// self-checking bench of the frame control over axi4-lite
// assumes the detector model on the flag inputs and the bound checker
`timescale 1ns/1ps
module testbench;
   import lmf_pkg::*;
   logic clk_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready, load;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rng, lo, hi, d;
   logic [47:0] ovl, svl;
   logic awready, wready, bvalid, arready, rvalid, irq, seg_active;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata;
   logic [47:0] open_f, short_f, cfg_first;
   logic [7:0] chip_idx, idx;
   logic [5:0] line_sel;
   logic [15:0] gs_data;
   int num_errors = 0, cmp_count = 0, k;
   lmf_frame_ctrl #(.MEM_WORDS(128)) uut (.clk_i, .sys_rst_i,
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .open_flag_i(open_f),
      .short_flag_i(short_f), .chip_index_o(chip_idx), .cfg_first_o(cfg_first),
      .line_sel_o(line_sel), .seg_active_o(seg_active), .gs_data_o(gs_data), .irq_o(irq));
   lmf_det_model det (.clk_i, .sys_rst_i, .load_i(load), .open_val_i(ovl),
      .short_val_i(svl), .open_flag_o(open_f), .short_flag_o(short_f));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic int cdiv(input int a, input int b);
      return (a + b - 1) / b;
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] e, input logic [47:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_rsp(input logic [1:0] e, input logic [1:0] g);
      chk({46'h0, e}, {46'h0, g});
   endtask
   task automatic hang(input int n);
      if (n >= 64) begin
         num_errors++;
         end_of_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      hang(n);
      chk_rsp(er, bresp);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rr);
      int n;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      dv = rdata;
      rr = rresp;
      rready <= 1'b0;
      hang(n);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                         input logic [1:0] er);
      rd(a, d, r);
      chk_rsp(er, r);
      chk({16'h0, e & m}, {16'h0, d & m});
   endtask
   task automatic sync_frame();
      wr(A_CMD, 32'h1, RESP_OKAY);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic run_frame(input logic [1:0] sel, input logic [3:0] code, input logic [5:0] bl);
      int n, hc = 0, lc = 0, seg;
      seg = (bl > 2) ? 8 + bl / 2 : 8;
      for (n = 0; n < 64; n++) begin
         repeat (12) @(posedge clk_i);
         rd(A_FRAME, d, r);
         if (d[13:12] == ST_IDLE) break;
      end
      hang(n);
      wr(A_CFG2, {16'h0, 6'd0, 6'd1, 2'b00, sel}, RESP_OKAY);
      wr(A_CFG1_LO, 32'd8, RESP_OKAY);
      wr(A_CFG1_HI, {23'h0, code, 5'h0}, RESP_OKAY);
      wr(A_BLANK, {26'h0, bl}, RESP_OKAY);
      wr(A_CMD, 32'h1, RESP_OKAY);
      for (n = 0; n < 64 && seg_active !== 1'b1; n++) @(posedge clk_i);
      hang(n);
      while (seg_active === 1'b1 && hc < 2000) begin
         @(posedge clk_i);
         hc++;
      end
      while (seg_active !== 1'b1 && lc < 2000) begin
         @(posedge clk_i);
         lc++;
      end
      chk(48'(cdiv(seg, sel + 1)), 48'(hc));
      chk(48'(cdiv((code + 1) * 30, sel + 1)), 48'(lc));
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {sys_rst_i, awvalid, wvalid, bready, arvalid, rready, load} = 7'h40;
      {awaddr, araddr, wdata, ovl, svl} = '0;
      rng = 32'h8cf99d9b;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      chk(48'h0, {40'h0, chip_idx});
      rd_chk(A_CHIP_IDX, 32'h0, 32'h1ff, RESP_OKAY);
      rng = xs(rng);
      idx = {1'b0, rng[6:0]} + 8'h1;
      wr(A_CHIP_IDX, {24'h0, idx}, RESP_OKAY);
      chk({40'h0, idx + 8'h1}, {40'h0, chip_idx});
      rd_chk(A_CHIP_IDX, {23'h0, 1'b1, idx}, 32'h1ff, RESP_OKAY);
      rd(A_FRAME, d, r);
      k = d[14];
      lo = xs(rng);
      hi = xs(lo);
      rng = hi;
      wr(A_TARGET, 32'h100, RESP_OKAY);
      wr(A_CFG0_LO, lo, RESP_OKAY);
      wr(A_CFG0_HI, hi, RESP_OKAY);
      chk(48'h0, cfg_first);
      sync_frame();
      chk({hi[15:0], lo}, cfg_first);
      rd_chk(A_STAT, 32'h1 << ST_FRAME_START, 32'h1 << ST_FRAME_START, RESP_OKAY);
      rd_chk(A_FRAME, {17'h0, ~k[0], 14'h0}, 32'h4000, RESP_OKAY);
      wr(A_TARGET, {24'h0, idx + 8'h1}, RESP_OKAY);
      wr(A_CFG0_LO, ~lo, RESP_OKAY);
      sync_frame();
      chk({hi[15:0], lo}, cfg_first);
      wr(A_TARGET, {24'h0, idx}, RESP_OKAY);
      wr(A_GS_DATA, 32'h0, RESP_OKAY);
      wr(A_CFG0_LO, ~lo, RESP_OKAY);
      sync_frame();
      chk({hi[15:0], ~lo}, cfg_first);
      run_frame(2'd0, 4'h3, 6'd0);
      run_frame(2'd1, 4'h0, 6'd20);
      for (k = 0; k < 3; k++) begin
         rng = xs(rng);
         run_frame(rng[1:0], rng[5:2], rng[11:6]);
      end
      run_frame(2'd0, 4'hf, 6'd0);
      rd(A_FRAME, d, r);
      chk(48'h1, {47'h0, d[13:12] != ST_IDLE});
      chk(48'h1, {42'h0, d[5:0]});
      wr(A_MASK, 32'h1 << ST_FAULT, RESP_OKAY);
      rng = xs(rng);
      ovl <= {rng[15:0], xs(rng)} | 48'h1;
      rng = xs(xs(rng));
      svl <= {rng[31:16], xs(rng)};
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      for (k = 0; k < 4; k++) begin
         rd_chk(A_FLAG_BASE + 8'(4 * k), 32'(ovl >> (12 * k)), 32'hfff, RESP_OKAY);
         rd_chk(A_FLAG_BASE + 8'(16 + 4 * k), 32'(svl >> (12 * k)), 32'hfff, RESP_OKAY);
      end
      chk(48'h1, {47'h0, irq});
      wr(A_STAT, 32'h1 << ST_FAULT, RESP_OKAY);
      repeat (2) @(posedge clk_i);
      chk(48'h0, {47'h0, irq});
      wr(A_MASK, 32'h0, RESP_OKAY);
      ovl <= ~ovl;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      rd_chk(A_STAT, 32'h1 << ST_FAULT, 32'h1 << ST_FAULT, RESP_OKAY);
      chk(48'h0, {47'h0, irq});
      wr(8'h38, 32'h1, RESP_SLVERR);
      wr(8'h06, 32'h1, RESP_SLVERR);
      rd_chk(8'h3c, 32'h0, 32'hffffffff, RESP_SLVERR);
      rd_chk(8'h60, 32'h0, 32'hffffffff, RESP_SLVERR);
      end_of_test();
   end
endmodule
bind lmf_frame_ctrl lmf_frame_ctrl_checker u_chk (.clk_i, .sys_rst_i, .s_axi_awaddr_i,
   .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
   .s_axi_bvalid_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
   .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .short_flag_i, .cfg_first_o, .irq_o);
